// ===== dv/i2c_master_model.sv
/*
  Bus master model: start, stop and nine-bit transfers, one bit every
  128 system clocks, so under 400 kbps at 50 MHz.
  Assumes the bench resolves SDA with a pull-up from both drivers.
*/
`timescale 1ns/1ns
module i2c_master_model (
  input  wire logic clk,
  input  wire logic sda,
  output logic      scl,
  output logic      sda_drv
);
  localparam int Q = 32;

  // Both lines released outside frames; SCL stands high
  initial begin
    scl     = 1'b1;
    sda_drv = 1'b1;
  end

  task automatic wt();
    repeat (Q) @(posedge clk);
  endtask : wt

  // Start or repeated start: SDA falls while SCL is high
  task automatic start();
    sda_drv <= 1'b1;
    wt();
    scl <= 1'b1;
    wt();
    sda_drv <= 1'b0;
    wt();
    scl <= 1'b0;
    wt();
  endtask : start

  // Stop: SDA rises while SCL is high
  task automatic stop();
    sda_drv <= 1'b0;
    wt();
    scl <= 1'b1;
    wt();
    sda_drv <= 1'b1;
    wt();
  endtask : stop

  // MSB first; SDA moves only while SCL is low
  task automatic xfer(input logic [8:0] tx, output logic [8:0] rx);
    for (int i = 8; i >= 0; i--) begin
      sda_drv <= tx[i];
      wt();
      scl <= 1'b1;
      wt();
      rx[i] = sda;
      wt();
      scl <= 1'b0;
      wt();
    end
  endtask : xfer
endmodule : i2c_master_model

// ===== dv/multi_address_i2c_slave_ram_tb.sv
/*
  Self-checking bench: registers over Wishbone, writes and reads of all
  four areas through the master model, refusals and the display.
  Assumes the master model of its own file and a pull-up on SDA.
*/
`timescale 1ns/1ns
module multi_address_i2c_slave_ram_tb;
  logic        clk = 1'b0;
  logic        reset = 1'b1;
  logic        cyc = 1'b0;
  logic        we = 1'b0;
  logic [7:0]  adr = 8'h00;
  logic [3:0]  sel = 4'h0;
  logic [31:0] dat = 32'h0;
  logic [31:0] rdat, rd;
  logic        ack, scl, sda, sda_o, sda_oe_n, sda_drv, bus_event;
  logic        sel_lower, sel_upper;
  logic [3:0]  led_data;
  logic [8:0]  rx;
  logic [6:0]  area [4] = '{7'h10, 7'h24, 7'h5A, 7'h6B};
  logic [6:0]  bad [4] = '{7'h50, 7'h11, 7'h7A, 7'h04};
  logic [7:0]  mem [4][3];
  int          n_errors = 0;
  int          samples_checked = 0;
  int          cycles = 0;
  int          ev = 0;
  int          n;
  int          seed;

  always #10 clk = ~clk;
  // Open-drain SDA with pull-up: either party pulling low wins
  assign sda = (sda_oe_n === 1'b0) ? (sda_o & sda_drv) : sda_drv;

  multi_address_i2c_slave_ram #(.REFRESH_CYCLES(16)) DUT (
    .clk(clk), .reset(reset), .scl_i(scl), .sda_i(sda),
    .sda_o(sda_o), .sda_oe_n(sda_oe_n), .bus_event(bus_event),
    .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .led_data(led_data), .sel_lower(sel_lower), .sel_upper(sel_upper)
  );

  i2c_master_model m (.clk(clk), .sda(sda), .scl(scl), .sda_drv(sda_drv));

  // Event pulses and the run-time ceiling
  always @(posedge clk) begin
    cycles++;
    if (bus_event === 1'b1)
      ev++;
    if (cycles == 90000) begin
      n_errors++;
      finish_test();
    end
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp,
                     input string what);
    samples_checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  // Active-low nibble of the shown address for one group select
  function automatic logic [3:0] exp_led(input logic [6:0] a,
                                         input logic       up);
    return up ? ~{1'b0, a[6:4]} : ~a[3:0];
  endfunction : exp_led

  // Classic cycle; request held until ack is sampled high
  task automatic wb(input logic w, input logic [7:0] a,
                    input logic [31:0] d, input logic [3:0] s);
    int k;
    k = 0;
    cyc <= 1'b1;
    we  <= w;
    adr <= a;
    dat <= d;
    sel <= s;
    @(posedge clk);
    while (ack !== 1'b1 && k < 20) begin
      @(posedge clk);
      k++;
    end
    if (k == 20)
      chk(ack, 1'b1, "wishbone ack");
    rd = rdat;
    cyc <= 1'b0;
    @(posedge clk);
  endtask : wb

  task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
    wb(1'b0, a, 32'h0, 4'hF);
    chk(rd, exp, "register");
  endtask : rchk

  task automatic finish_test();
    $display("checks %0d errors %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : finish_test

  // Main sequence
  initial begin
    seed = 32'h4A8BF9DE;
    repeat (5) @(posedge clk);
    reset <= 1'b0;
    repeat (6) @(posedge clk);
    rchk(8'h00, 32'(i2c_ram_pkg::OWN_ADDR_RST));
    rchk(8'h04, 32'h1C);
    rchk(8'h08, 32'h4D);
    rchk(8'h0C, 32'h03);
    wb(1'b1, 8'h00, 32'hA5, 4'h1);
    rchk(8'h00, 32'hA4);
    rchk(8'h20, 32'h0);
    // Pointer FF in every area: wrap and area isolation both show
    foreach (area[a]) begin
      for (int k = 0; k < 3; k++)
        mem[a][k] = 8'($random(seed));
      ev = 0;
      m.start();
      m.xfer({area[a], 2'b01}, rx);
      chk(32'(rx[0]), 32'h0, "address ack");
      m.xfer({8'hFF, 1'b1}, rx);
      for (int k = 0; k < 3; k++) begin
        m.xfer({mem[a][k], 1'b1}, rx);
        chk(32'(rx[0]), 32'h0, "data ack");
      end
      m.stop();
      repeat (16) @(posedge clk);
      chk(ev, 7, "event count");
    end
    foreach (area[a]) begin
      m.start();
      m.xfer({area[a], 2'b01}, rx);
      m.xfer({8'hFF, 1'b1}, rx);
      m.start();
      m.xfer({area[a], 2'b11}, rx);
      for (int k = 0; k < 3; k++) begin
        m.xfer({8'hFF, k == 2}, rx);
        chk(rx[8:1], mem[a][k], "read data");
      end
      m.stop();
    end
    // Invalid and extension addresses are left unanswered
    foreach (bad[b]) begin
      m.start();
      m.xfer({bad[b], 2'b01}, rx);
      chk(32'(rx[0]), 32'h1, "refused ack");
      m.stop();
    end
    rchk(8'h10, 32'h16B);
    wb(1'b1, 8'h10, 32'h100, 4'h2);
    rchk(8'h10, 32'h06B);
    // Align to a true rise of the lower select, not mid-phase
    n = 0;
    while (sel_upper !== 1'b1 && n < 64) begin
      @(posedge clk);
      n++;
    end
    n = 0;
    while (sel_lower !== 1'b1 && n < 64) begin
      @(posedge clk);
      n++;
    end
    chk(led_data, exp_led(area[3], 1'b0), "lower digit");
    n = 0;
    while (sel_upper !== 1'b1 && n < 64) begin
      @(posedge clk);
      n++;
    end
    chk(led_data, exp_led(area[3], 1'b1), "upper digit");
    chk(n, 16, "refresh period");
    // Match-all off: only the own address (A5h written, LSB dropped)
    wb(1'b1, 8'h08, 32'h0D, 4'h1);
    for (int k = 0; k < 2; k++) begin
      m.start();
      m.xfer({(k ? area[0] : 7'(8'hA5 >> 1)), 2'b01}, rx);
      chk(32'(rx[0]), 32'(k), "own address ack");
      m.stop();
    end
    finish_test();
  end
endmodule : multi_address_i2c_slave_ram_tb

// ===== hw/byte_store.sv
/*
  Single-port byte memory holding all four areas, with registered read.
  Assumes the controller holds the address steady while it waits.
*/
`timescale 1ns/1ns
module byte_store #(
  parameter int AW = 10,
  parameter int DW = 8
) (
  input wire logic clk,
  ram_if.store     bus
);
  logic [DW-1:0] mem [2**AW];

  // Read first: a same-cycle write is not seen; read data lands one cycle after the address
  always_ff @(posedge clk) begin
    if (bus.we) begin
      mem[bus.addr] <= bus.wdata;
    end
    bus.rdata <= mem[bus.addr];
  end
endmodule : byte_store

// ===== hw/i2c_ram_pkg.sv
/*
  Shared constants for the multi-address serial RAM slave: valid bus
  addresses, register offsets, field positions, reset values, display
  timing and the protocol state encoding.
  Assumes a 50 MHz system clock and 32-bit classic Wishbone registers.
*/
package i2c_ram_pkg;

  // Bus addresses that select the four memory areas
  localparam logic [6:0] AREA0_ADDR = 7'h10;
  localparam logic [6:0] AREA1_ADDR = 7'h24;
  localparam logic [6:0] AREA2_ADDR = 7'h5A;
  localparam logic [6:0] AREA3_ADDR = 7'h6B;
  localparam int         AREA_W     = 2;
  localparam int         PTR_W      = 8;

  // Register byte offsets on the Wishbone port
  localparam logic [7:0] OWN_ADDR_OFS = 8'h00;
  localparam logic [7:0] CTRL_A_OFS   = 8'h04;
  localparam logic [7:0] CTRL_B_OFS   = 8'h08;
  localparam logic [7:0] BUS_FLAG_OFS = 8'h0C;
  localparam logic [7:0] STATUS_OFS   = 8'h10;
  localparam logic [7:0] EV_CNT_OFS   = 8'h14;

  // Values after reset
  localparam logic [7:0] OWN_ADDR_RST = 8'h50;
  localparam logic [7:0] CTRL_A_RST   = 8'h1C;
  localparam logic [7:0] CTRL_B_RST   = 8'h4D;
  localparam logic [7:0] BUS_FLAG_RST = 8'h03;

  // Field positions
  localparam int CA_ACK_EN    = 2;
  localparam int CA_WAIT_9TH  = 3;
  localparam int CA_STOP_IE   = 4;
  localparam int CB_DIV2      = 0;
  localparam int CB_FILTER    = 2;
  localparam int CB_FAST      = 3;
  localparam int CB_MATCH_ALL = 6;
  localparam int BF_RES_DIS   = 0;
  localparam int BF_BUS_FREE  = 1;
  localparam int ST_LEAVE     = 8;

  // Display refresh: timer clock, data value, derived cycle count
  localparam longint TIMER_CLK_HZ   = 8_000_000;
  localparam longint TIMER_DATA     = 40000;
  localparam longint CLK_PERIOD_NS  = 20;
  localparam longint REFRESH_NS     = TIMER_DATA * 1_000_000_000
                                      / TIMER_CLK_HZ;
  localparam int     REFRESH_CYCLES = int'(REFRESH_NS / CLK_PERIOD_NS);
  localparam logic   LED_ON         = 1'b0;

  // Protocol states, one-hot
  typedef enum logic [6:0] {
    ST_IDLE  = 7'b0000001,
    ST_ADDR  = 7'b0000010,
    ST_ACK   = 7'b0000100,
    ST_RX    = 7'b0001000,
    ST_TX    = 7'b0010000,
    ST_TXACK = 7'b0100000,
    ST_OUT   = 7'b1000000
  } slave_state_e;

endpackage : i2c_ram_pkg

// ===== hw/led_scan.sv
/*
  Multiplexed display of one byte on four shared data lines with two
  group selects, switched by a free-running refresh interval timer.
  Assumes data lines are active low and selects active high.
*/
`timescale 1ns/1ns
module led_scan #(
  parameter int PERIOD = i2c_ram_pkg::REFRESH_CYCLES
) (
  input  wire logic       clk,
  input  wire logic       reset,
  input  wire logic [7:0] disp,
  output logic      [3:0] led_data,
  output logic            sel_lower,
  output logic            sel_upper
);
  localparam int CW = $clog2(PERIOD);
  localparam logic [CW-1:0] LAST = CW'(PERIOD - 1);

  logic [CW-1:0] cnt_r;
  logic          phase_r;

  // Interval timer, one tick per refresh period
  always_ff @(posedge clk) begin
    if (reset) begin
      cnt_r   <= '0;
      phase_r <= 1'b0;
    end else if (cnt_r == LAST) begin
      cnt_r   <= '0;
      phase_r <= ~phase_r;
    end else begin
      cnt_r <= cnt_r + 1'b1;
    end
  end

  // Group select and data, registered so outputs never glitch
  always_ff @(posedge clk) begin
    if (reset) begin
      led_data  <= {4{~i2c_ram_pkg::LED_ON}};
      sel_lower <= 1'b0;
      sel_upper <= 1'b0;
    end else begin
      led_data  <= phase_r ? ~disp[7:4] : ~disp[3:0];
      sel_lower <= ~phase_r;
      sel_upper <= phase_r;
    end
  end
endmodule : led_scan

// ===== hw/multi_address_i2c_slave_ram.sv
/*
  Serial bus slave answering four addresses, each opening its own
  256-byte area with a self-incrementing pointer, plus a register file
  on classic Wishbone and a multiplexed display of the last address.
  Assumes the bus master keeps to fast-mode timing and that SCL and SDA
  pins are asynchronous; SCL is never stretched by this block.
*/
// Register access over Wishbone and the register offsets are this design's own decisions.
`timescale 1ns/1ns
// What this block does
// - Accept addresses 10h, 24h, 5Ah for areas 0-2
// - Address 6Bh selects area 3; others invalid
// - Extension codes are ignored, slave withdraws
// - Fast mode, master at most 400 kbps
// - Own address in upper seven bits, LSB zero
// - Match-all raises event at 8th falling edge
// - Acknowledge valid address, else leave the bus
// - Wait timing set adds 9th-edge event
// - First byte after address is pointer
// - Write: set pointer, store further bytes sequentially
// - Read sends bytes from previously set pointer
// - Pointer increments after every byte
// - Pointer wraps from FFh to 00h
// - Pointer never changes the selected area
// - Display shows last received valid address
// - Control register A resets to 1Ch
// - Control register B resets to 4Dh
// - Bus flag register resets to 03h
// - Refresh every 40000 ticks of 8 MHz
// - Four data lines, lower and upper selects
module multi_address_i2c_slave_ram #(
  parameter int REFRESH_CYCLES = i2c_ram_pkg::REFRESH_CYCLES
) (
  input  wire logic        clk,
  input  wire logic        reset,
  input  wire logic        scl_i,
  input  wire logic        sda_i,
  output logic             sda_o,
  output logic             sda_oe_n,
  output logic             bus_event,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  output logic      [3:0]  led_data,
  output logic             sel_lower,
  output logic             sel_upper
);
  i2c_ram_pkg::slave_state_e state_r;

  logic       scl_m_r, scl_s_r, sda_m_r, sda_s_r;
  logic       scl_p_r, sda_p_r, scl_f_r, sda_f_r;
  logic       scl_d_r, sda_d_r, div_r;
  logic [3:0] bitcnt_r;
  logic [7:0] sh_r, tx_r;
  logic       rw_r, reg_got_r, mack_r, busy_r, leave_r;
  logic [1:0] area_r;
  logic [6:0] last_addr_r;
  logic [7:0] own_addr_r, ctrl_a_r, ctrl_b_r, ev_cnt_r;
  logic       res_dis_r;
  logic [7:0] ptr_r [4];

  logic       tick, scl_rise, scl_fall, start_c, stop_c;
  logic       byte_done, addr_done, rx_done, ptr_load, mem_wr;
  logic       tx_load, ninth_fall, ev_c, wb_req, leave_set;
  logic [2:0] dec_c;
  logic [7:0] cur_ptr_c;

  ram_if #(.AW(10), .DW(8)) ram_bus ();

  // Area decode: bit 2 is hit, bits 1:0 the area
  function automatic logic [2:0] area_of(input logic [6:0] a,
                                         input logic       all,
                                         input logic [6:0] own);
    logic [2:0] r;
    r = 3'h0;
    if (!all) begin
      r = {a == own, 2'h0};
    end else if (a[6:3] == 4'h0 || a[6:3] == 4'hF) begin
      r = 3'h0;
    end else begin
      case (a)
        i2c_ram_pkg::AREA0_ADDR: r = 3'h4;
        i2c_ram_pkg::AREA1_ADDR: r = 3'h5;
        i2c_ram_pkg::AREA2_ADDR: r = 3'h6;
        i2c_ram_pkg::AREA3_ADDR: r = 3'h7;
        default:                 r = 3'h0;
      endcase
    end
    return r;
  endfunction : area_of

  // Two-stage synchronisers on the bus pins
  always_ff @(posedge clk) begin
    if (reset) begin
      scl_m_r <= 1'b1;
      scl_s_r <= 1'b1;
      sda_m_r <= 1'b1;
      sda_s_r <= 1'b1;
    end else begin
      scl_m_r <= scl_i;
      scl_s_r <= scl_m_r;
      sda_m_r <= sda_i;
      sda_s_r <= sda_m_r;
    end
  end

  // Bus unit runs at half rate when the divider bit is set
  always_ff @(posedge clk) begin
    if (reset) begin
      div_r <= 1'b0;
    end else begin
      div_r <= ~div_r;
    end
  end
  assign tick = ~ctrl_b_r[i2c_ram_pkg::CB_DIV2] | div_r;

  // Spike filter: a level passes once seen on two unit ticks
  always_ff @(posedge clk) begin
    if (reset) begin
      scl_p_r <= 1'b1;
      sda_p_r <= 1'b1;
      scl_f_r <= 1'b1;
      sda_f_r <= 1'b1;
    end else if (tick) begin
      scl_p_r <= scl_s_r;
      sda_p_r <= sda_s_r;
      if (!ctrl_b_r[i2c_ram_pkg::CB_FILTER] || scl_s_r == scl_p_r) begin
        scl_f_r <= scl_s_r;
      end
      if (!ctrl_b_r[i2c_ram_pkg::CB_FILTER] || sda_s_r == sda_p_r) begin
        sda_f_r <= sda_s_r;
      end
    end
  end

  // Edge history of the filtered lines
  always_ff @(posedge clk) begin
    if (reset) begin
      scl_d_r <= 1'b1;
      sda_d_r <= 1'b1;
    end else begin
      scl_d_r <= scl_f_r;
      sda_d_r <= sda_f_r;
    end
  end

  // Line events and byte-level decode
  assign scl_rise   = scl_f_r & ~scl_d_r;
  assign scl_fall   = ~scl_f_r & scl_d_r;
  assign start_c    = scl_f_r & scl_d_r & ~sda_f_r & sda_d_r;
  assign stop_c     = scl_f_r & scl_d_r & sda_f_r & ~sda_d_r;
  assign byte_done  = scl_fall && bitcnt_r == 4'h8;
  assign addr_done  = byte_done && state_r == i2c_ram_pkg::ST_ADDR;
  assign rx_done    = byte_done && state_r == i2c_ram_pkg::ST_RX;
  assign ptr_load   = rx_done && !reg_got_r;
  assign mem_wr     = rx_done && reg_got_r;
  assign ninth_fall = scl_fall && (state_r == i2c_ram_pkg::ST_ACK ||
                                   state_r == i2c_ram_pkg::ST_TXACK);
  assign tx_load    = scl_fall &&
                      ((state_r == i2c_ram_pkg::ST_ACK && rw_r) ||
                       (state_r == i2c_ram_pkg::ST_TXACK && mack_r));
  assign dec_c      = area_of(sh_r[7:1],
                              ctrl_b_r[i2c_ram_pkg::CB_MATCH_ALL],
                              own_addr_r[7:1]);
  assign leave_set  = addr_done &&
                      !(dec_c[2] && ctrl_a_r[i2c_ram_pkg::CA_ACK_EN]);
  assign cur_ptr_c  = ptr_r[area_r];

  // Memory port: area from the address, offset from its pointer
  assign ram_bus.addr  = {area_r, cur_ptr_c};
  assign ram_bus.wdata = sh_r;
  assign ram_bus.we    = mem_wr;

  // Protocol engine; start or stop overrides any state
  always_ff @(posedge clk) begin
    if (reset) begin
      state_r   <= i2c_ram_pkg::ST_IDLE;
      bitcnt_r  <= 4'h0;
      sh_r      <= 8'h00;
      tx_r      <= 8'h00;
      rw_r      <= 1'b0;
      area_r    <= 2'h0;
      reg_got_r <= 1'b0;
      mack_r    <= 1'b0;
      sda_oe_n  <= 1'b1;
    end else if (stop_c) begin
      state_r  <= i2c_ram_pkg::ST_IDLE;
      sda_oe_n <= 1'b1;
    end else if (start_c) begin
      state_r  <= i2c_ram_pkg::ST_ADDR;
      bitcnt_r <= 4'h0;
      sda_oe_n <= 1'b1;
    end else begin
      case (state_r)
        i2c_ram_pkg::ST_ADDR, i2c_ram_pkg::ST_RX: begin
          if (scl_rise) begin
            sh_r     <= {sh_r[6:0], sda_f_r};
            bitcnt_r <= bitcnt_r + 4'h1;
          end else if (byte_done) begin
            bitcnt_r <= 4'h0;
            if (leave_set) begin
              state_r <= i2c_ram_pkg::ST_OUT;
            end else if (state_r == i2c_ram_pkg::ST_ADDR) begin
              state_r  <= i2c_ram_pkg::ST_ACK;
              sda_oe_n <= 1'b0;
              rw_r     <= sh_r[0];
              area_r   <= dec_c[1:0];
              if (!sh_r[0]) begin
                reg_got_r <= 1'b0;
              end
            end else if (ctrl_a_r[i2c_ram_pkg::CA_ACK_EN]) begin
              state_r   <= i2c_ram_pkg::ST_ACK;
              sda_oe_n  <= 1'b0;
              reg_got_r <= 1'b1;
            end else begin
              state_r <= i2c_ram_pkg::ST_OUT;
            end
          end
        end
        i2c_ram_pkg::ST_ACK: begin
          if (tx_load) begin
            state_r  <= i2c_ram_pkg::ST_TX;
            tx_r     <= ram_bus.rdata;
            sda_oe_n <= ram_bus.rdata[7];
          end else if (scl_fall) begin
            state_r  <= i2c_ram_pkg::ST_RX;
            sda_oe_n <= 1'b1;
          end
        end
        i2c_ram_pkg::ST_TX: begin
          if (scl_rise) begin
            bitcnt_r <= bitcnt_r + 4'h1;
          end else if (byte_done) begin
            state_r  <= i2c_ram_pkg::ST_TXACK;
            bitcnt_r <= 4'h0;
            sda_oe_n <= 1'b1;
          end else if (scl_fall) begin
            tx_r     <= {tx_r[6:0], 1'b0};
            sda_oe_n <= tx_r[6];
          end
        end
        i2c_ram_pkg::ST_TXACK: begin
          if (scl_rise) begin
            mack_r <= ~sda_f_r;
          end else if (tx_load) begin
            state_r  <= i2c_ram_pkg::ST_TX;
            tx_r     <= ram_bus.rdata;
            sda_oe_n <= ram_bus.rdata[7];
          end else if (scl_fall) begin
            state_r <= i2c_ram_pkg::ST_OUT;
          end
        end
        i2c_ram_pkg::ST_IDLE, i2c_ram_pkg::ST_OUT: begin
          sda_oe_n <= 1'b1;
        end
        default: begin
          state_r  <= i2c_ram_pkg::ST_IDLE;
          sda_oe_n <= 1'b1;
        end
      endcase
    end
  end

  // Open drain: the driven level is always low
  always_ff @(posedge clk) begin
    sda_o <= 1'b0;
  end

  // Per-area pointers survive stop and other areas' traffic
  always_ff @(posedge clk) begin
    if (reset) begin
      for (int i = 0; i < 4; i++) begin
        ptr_r[i] <= 8'h00;
      end
    end else if (ptr_load) begin
      ptr_r[area_r] <= sh_r;
    end else if (mem_wr || tx_load) begin
      ptr_r[area_r] <= cur_ptr_c + 8'h01;
    end
  end

  // Bus events: address at 8th edge, 9th edge with wait timing
  assign ev_c = (addr_done && (ctrl_b_r[i2c_ram_pkg::CB_MATCH_ALL]
                               || dec_c[2])) ||
                (byte_done && state_r != i2c_ram_pkg::ST_ADDR &&
                 !ctrl_a_r[i2c_ram_pkg::CA_WAIT_9TH]) ||
                (ninth_fall && ctrl_a_r[i2c_ram_pkg::CA_WAIT_9TH]) ||
                (stop_c && busy_r && ctrl_a_r[i2c_ram_pkg::CA_STOP_IE]);

  always_ff @(posedge clk) begin
    if (reset) begin
      bus_event <= 1'b0;
      ev_cnt_r  <= 8'h00;
    end else begin
      bus_event <= ev_c;
      ev_cnt_r  <= ev_cnt_r + {7'h00, ev_c};
    end
  end

  // Bus busy between start and stop; last valid address kept
  always_ff @(posedge clk) begin
    if (reset) begin
      busy_r      <= 1'b0;
      last_addr_r <= 7'h00;
    end else begin
      if (start_c) begin
        busy_r <= 1'b1;
      end else if (stop_c) begin
        busy_r <= 1'b0;
      end
      if (addr_done && dec_c[2]) begin
        last_addr_r <= sh_r[7:1];
      end
    end
  end

  // Classic Wishbone slave: ack one cycle after the strobe
  assign wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;

  always_ff @(posedge clk) begin
    if (reset) begin
      wb_ack_o   <= 1'b0;
      wb_dat_o   <= 32'h0000_0000;
      own_addr_r <= i2c_ram_pkg::OWN_ADDR_RST;
      ctrl_a_r   <= i2c_ram_pkg::CTRL_A_RST;
      ctrl_b_r   <= i2c_ram_pkg::CTRL_B_RST;
      res_dis_r  <= i2c_ram_pkg::BUS_FLAG_RST[i2c_ram_pkg::BF_RES_DIS];
    end else begin
      wb_ack_o <= wb_req;
      if (wb_req && wb_we_i && wb_sel_i[0]) begin
        case (wb_adr_i)
          i2c_ram_pkg::OWN_ADDR_OFS: own_addr_r <= {wb_dat_i[7:1], 1'b0};
          i2c_ram_pkg::CTRL_A_OFS:   ctrl_a_r   <= wb_dat_i[7:0];
          i2c_ram_pkg::CTRL_B_OFS:   ctrl_b_r   <= wb_dat_i[7:0];
          i2c_ram_pkg::BUS_FLAG_OFS: res_dis_r  <= wb_dat_i[0];
          default: ;
        endcase
      end
      case (wb_adr_i)
        i2c_ram_pkg::OWN_ADDR_OFS: wb_dat_o <= {24'h0, own_addr_r};
        i2c_ram_pkg::CTRL_A_OFS:   wb_dat_o <= {24'h0, ctrl_a_r};
        i2c_ram_pkg::CTRL_B_OFS:   wb_dat_o <= {24'h0, ctrl_b_r};
        i2c_ram_pkg::BUS_FLAG_OFS: wb_dat_o <= {30'h0, ~busy_r, res_dis_r};
        i2c_ram_pkg::STATUS_OFS:   wb_dat_o <= {23'h0, leave_r, 1'b0,
                                                last_addr_r};
        i2c_ram_pkg::EV_CNT_OFS:   wb_dat_o <= {24'h0, ev_cnt_r};
        default:                   wb_dat_o <= 32'h0000_0000;
      endcase
    end
  end

  // Leave flag: hardware set beats a same-cycle write-one clear
  always_ff @(posedge clk) begin
    if (reset) begin
      leave_r <= 1'b0;
    end else if (leave_set) begin
      leave_r <= 1'b1;
    end else if (wb_req && wb_we_i && wb_sel_i[1] &&
                 wb_adr_i == i2c_ram_pkg::STATUS_OFS &&
                 wb_dat_i[i2c_ram_pkg::ST_LEAVE]) begin
      leave_r <= 1'b0;
    end
  end

  byte_store #(.AW(10), .DW(8)) u_store (
    .clk (clk),
    .bus (ram_bus)
  );

  led_scan #(.PERIOD(REFRESH_CYCLES)) u_led (
    .clk       (clk),
    .reset     (reset),
    .disp      ({1'b0, last_addr_r}),
    .led_data  (led_data),
    .sel_lower (sel_lower),
    .sel_upper (sel_upper)
  );

  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  sequence s_valid_addr;
    addr_done && dec_c[2] && ctrl_a_r[i2c_ram_pkg::CA_ACK_EN];
  endsequence
  sequence s_ack_driven;
    state_r == i2c_ram_pkg::ST_ACK && !sda_oe_n;
  endsequence

  property p_ack_valid;
    s_valid_addr |=> s_ack_driven;
  endproperty
  a_ack_valid: assert property (p_ack_valid)
    else $error("valid address not acknowledged");

  property p_area3;
    s_valid_addr and (sh_r[7:1] == i2c_ram_pkg::AREA3_ADDR &&
      ctrl_b_r[i2c_ram_pkg::CB_MATCH_ALL]) |=> area_r == 2'h3;
  endproperty
  a_area3: assert property (p_area3)
    else $error("fourth address did not select area 3");

  property p_ext_code;
    addr_done && sh_r[7:4] == 4'hF |=>
      state_r == i2c_ram_pkg::ST_OUT && sda_oe_n && leave_r;
  endproperty
  a_ext_code: assert property (p_ext_code)
    else $error("extension code not ignored");

  property p_event_8th;
    addr_done && ctrl_b_r[i2c_ram_pkg::CB_MATCH_ALL] |=> bus_event;
  endproperty
  a_event_8th: assert property (p_event_8th)
    else $error("no event at 8th falling edge of address");

  property p_event_9th;
    s_ack_driven ##0 (scl_fall && ctrl_a_r[i2c_ram_pkg::CA_WAIT_9TH])
      |=> bus_event ##1 !bus_event;
  endproperty
  a_event_9th: assert property (p_event_9th)
    else $error("no single event at 9th falling edge");

  property p_ptr_load;
    ptr_load |=> cur_ptr_c == $past(sh_r);
  endproperty
  a_ptr_load: assert property (p_ptr_load)
    else $error("pointer not taken from first data byte");

  property p_ptr_inc;
    mem_wr || tx_load |=> cur_ptr_c == 8'($past(cur_ptr_c) + 8'h01);
  endproperty
  a_ptr_inc: assert property (p_ptr_inc)
    else $error("pointer did not advance after a byte");

  property p_wrap;
    mem_wr && cur_ptr_c == 8'hFF |=> cur_ptr_c == 8'h00;
  endproperty
  a_wrap: assert property (p_wrap)
    else $error("pointer did not wrap to zero");

  property p_area_hold;
    !addr_done |=> $stable(area_r);
  endproperty
  a_area_hold: assert property (p_area_hold)
    else $error("area changed without an address");

  property p_stop_idle;
    stop_c |=> state_r == i2c_ram_pkg::ST_IDLE && sda_oe_n;
  endproperty
  a_stop_idle: assert property (p_stop_idle)
    else $error("stop did not return to idle");
endmodule : multi_address_i2c_slave_ram

// ===== hw/ram_if.sv
/*
  Port bundle between the protocol engine and its byte store.
  Assumes one clock; read data is registered inside the store.
*/
`timescale 1ns/1ns
interface ram_if #(
  parameter int AW = 10,
  parameter int DW = 8
);
  logic [AW-1:0] addr;
  logic [DW-1:0] wdata;
  logic [DW-1:0] rdata;
  logic          we;
  modport ctrl  (output addr, output wdata, output we, input rdata);
  modport store (input addr, input wdata, input we, output rdata);
endinterface : ram_if
